/* core/hmc_ctrl.sv */
`timescale 1ns/100ps
// Purpose: Register file, aliasing and control of a 32-bit multiplier.
// Assumes: Register port is driven by logic on the same system clock.
// Notes:   One pending write slot; a later blocked write replaces it.
//
// Overview of operation
// - 16-bit and 32-bit low-word operand-one names reach the same storage.
// - Result low/high word names alias result words 0 and 1.
// - Control bits 15 to 10 and bit 1 always read zero.
// - Delayed writes wait for 64-bit result, or 32-bit when select is set.
// - Write delay applies only while the delayed-write enable is set.
// - Operand two is 16 bits when its width bit is 0, else 32.
// - Operand one is 16 bits when its width bit is 0, else 32.
// - Mode field: unsigned, signed, unsigned accumulate, signed accumulate.
// - Saturation bit set clamps results; clear leaves them unsaturated.
// - Fractional bit set shifts results as fractions; clear gives integers.
// - Carry bit follows the result carry, acting as bit 33 or 65.
// - Switching saturation or fractional mode loads the carry bit from bit 0 of the control write.
// - Carry is writable and rebuilds the sum extension in unsigned accumulate mode.
// - Control register sits at offset 2Ch; upper byte resets to zero.
module hmc_ctrl (
  input  wire logic                        CLK_SYS_I,
  input  wire logic                        SYS_RST_I,
  input  wire logic [hmc_pkg::ADDR_W-1:0]  ADDR_I,
  input  wire logic [hmc_pkg::DATA_W-1:0]  WR_DATA_I,
  input  wire logic                        BYTE_I,
  input  wire logic                        WR_STB_I,
  input  wire logic                        RD_STB_I,
  output logic      [hmc_pkg::DATA_W-1:0]  RD_DATA_O,
  output logic                             RESULT_BUSY_O
);
  import hmc_pkg::*;

  typedef struct packed {
    logic [15:0] ctl;
    logic [31:0] op1;
    logic [31:0] op2;
    logic [15:0] result_word_0;
    logic [15:0] result_word_1;
    logic [15:0] res2;
    logic [15:0] result_word_3;
    logic [15:0] sum_extension;
    logic [63:0] stage_res;
    logic        stage_carry;
    logic [15:0] stage_sum_extension;
    logic        pend_v;
    logic [5:0]  pend_addr;
    logic [15:0] pend_data;
    logic        pend_byte;
    logic [15:0] rd_data;
    logic        busy;
  } hmc_ctrl_state_t;

  hmc_ctrl_state_t r_reg;
  hmc_ctrl_state_t r_next;

  hmc_seq_if sq ();

  logic        gate_open;
  logic        take_pend;
  logic        take_new;
  logic        w_en;
  logic [5:0]  w_addr;
  logic [15:0] w_data;
  logic        w_byte;
  logic        w_op1_lo;
  logic        w_op1_hi;
  logic [1:0]  w_op1_mode;
  logic        w_operand;
  logic        w_sign;
  logic [15:0] w_old;
  logic [15:0] w_merged;
  logic        start_c;
  logic        narrow_c;
  logic        sgn_c;
  logic        accm_c;
  logic [31:0] a_op;
  logic [31:0] b_op;
  logic [32:0] a_x;
  logic [32:0] b_x;
  logic [65:0] prod;
  logic [63:0] p64;
  logic [63:0] acc64;
  logic [32:0] sum33;
  logic [64:0] sum65;
  logic [31:0] r32;
  logic [63:0] res_c;
  logic        carry_c;
  logic        ovf_c;
  logic        msb_c;
  logic [15:0] sum_extension_c;
  logic [15:0] rd_val;

  ////////////////////////////////////////////////////////////////////////////
  // Readable value of a register address, aliases folded together
  function automatic logic [15:0] reg_value(input hmc_ctrl_state_t s,
                                            input logic [5:0]      a);
    logic [15:0] v;
    v = 16'h0000;
    if (a[5:3] == OFS_OP1_16[5:3] || (a[5:4] == OFS_OP1_32[5:4] && !a[1])) begin
      v = s.op1[15:0];
    end else if (a[5:4] == OFS_OP1_32[5:4]) begin
      v = s.op1[31:16];
    end else begin
      case (a[5:1])
        OFS_OP2[5:1], OFS_OP2_LOW[5:1]: v = s.op2[15:0];
        OFS_OP2_HIGH[5:1]:              v = s.op2[31:16];
        OFS_RESULT_LOW[5:1], OFS_RESULT_W0[5:1]:  v = s.result_word_0;
        OFS_RESULT_HIGH[5:1], OFS_RESULT_W1[5:1]: v = s.result_word_1;
        OFS_RESULT_W2[5:1]:             v = s.res2;
        OFS_RESULT_W3[5:1]:             v = s.result_word_3;
        OFS_SUM_EXT[5:1]: begin
          if (s.ctl[CTL_MODE_LSB +: 2] == MODE_UMAC) begin
            v = {15'h0000, s.ctl[CTL_CARRY_BIT]};
          end else begin
            v = s.sum_extension;
          end
        end
        OFS_CTL[5:1]:                   v = s.ctl & CTL_RW_MASK;
        default:                        v = 16'h0000;
      endcase
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write source: pending slot first, then the bus
  always_comb begin
    gate_open = 1'b1;
    if (r_reg.ctl[CTL_DLY_EN_BIT]) begin
      // wait for 32 or 64 bits
      gate_open = r_reg.ctl[CTL_DLY_SEL_BIT] ? !sq.lo_busy : !sq.hi_busy;
    end
    take_pend  = r_reg.pend_v && gate_open;
    take_new   = WR_STB_I && gate_open && !r_reg.pend_v;
    w_en       = take_pend || take_new;
    w_addr     = take_pend ? r_reg.pend_addr : ADDR_I;
    w_data     = take_pend ? r_reg.pend_data : WR_DATA_I;
    w_byte     = take_pend ? r_reg.pend_byte : BYTE_I;
    w_op1_lo   = (w_addr[5:3] == OFS_OP1_16[5:3]) ||
                 (w_addr[5:4] == OFS_OP1_32[5:4] && !w_addr[1]);
    w_op1_hi   = (w_addr[5:4] == OFS_OP1_32[5:4]) && w_addr[1];
    w_op1_mode = (w_addr[5:3] == OFS_OP1_16[5:3]) ? w_addr[2:1] : w_addr[3:2];
    w_operand  = w_op1_lo || w_op1_hi || (w_addr[5:1] == OFS_OP2[5:1]) ||
                 (w_addr[5:1] == OFS_OP2_LOW[5:1]) ||
                 (w_addr[5:1] == OFS_OP2_HIGH[5:1]);
    w_sign     = (w_op1_lo || w_op1_hi) ? w_op1_mode[0] : r_reg.ctl[CTL_MODE_LSB];
    w_old      = reg_value(r_reg, w_addr);
  end

  hmc_lane_merge u_merge (
    .old_i     (w_old),
    .wdata_i   (w_data),
    .byte_i    (w_byte),
    .hi_lane_i (w_addr[0]),
    .ext_i     (w_operand),
    .sign_i    (w_sign),
    .new_o     (w_merged)
  );

  hmc_seq u_seq (
    .clk_i (CLK_SYS_I),
    .rst_i (SYS_RST_I),
    .sq    (sq.seq)
  );

  assign sq.start  = start_c;
  assign sq.narrow = narrow_c;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    r_next   = r_reg;
    start_c  = 1'b0;
    sum33    = 33'h000000000;
    sum65    = 65'h00000000000000000;
    r32      = 32'h00000000;
    res_c    = 64'h0000000000000000;
    carry_c  = 1'b0;
    ovf_c    = 1'b0;
    msb_c    = 1'b0;
    sum_extension_c = 16'h0000;
    rd_val   = 16'h0000;

    // Results land before any write of this cycle, so software wins
    if (sq.lo_done) begin
      r_next.result_word_0 = r_reg.stage_res[15:0];
      r_next.result_word_1 = r_reg.stage_res[31:16];
    end
    if (sq.hi_done) begin
      r_next.res2   = r_reg.stage_res[47:32];
      r_next.result_word_3   = r_reg.stage_res[63:48];
      r_next.sum_extension = r_reg.stage_sum_extension;
      // besides control writes, only a finished product moves carry
      r_next.ctl[CTL_CARRY_BIT] = r_reg.stage_carry;
    end

    if (w_en) begin
      if (w_op1_lo) begin
        r_next.op1[15:0]                 = w_merged;
        r_next.ctl[CTL_MODE_LSB +: 2]    = w_op1_mode;
        r_next.ctl[CTL_OP1W_BIT]         = 1'b0;
      end else if (w_op1_hi) begin
        r_next.op1[31:16]                = w_merged;
        r_next.ctl[CTL_MODE_LSB +: 2]    = w_op1_mode;
        r_next.ctl[CTL_OP1W_BIT]         = 1'b1;
      end else begin
        case (w_addr[5:1])
          OFS_OP2[5:1]: begin
            r_next.op2[15:0]         = w_merged;
            r_next.ctl[CTL_OP2W_BIT] = 1'b0;
            start_c                  = 1'b1;
          end
          OFS_OP2_LOW[5:1]: begin
            r_next.op2[15:0] = w_merged;
            // wide operand waits for high word
            start_c          = !r_reg.ctl[CTL_OP2W_BIT];
          end
          OFS_OP2_HIGH[5:1]: begin
            r_next.op2[31:16]        = w_merged;
            r_next.ctl[CTL_OP2W_BIT] = 1'b1;
            start_c                  = 1'b1;
          end
          OFS_RESULT_LOW[5:1], OFS_RESULT_W0[5:1]:  r_next.result_word_0 = w_merged;
          OFS_RESULT_HIGH[5:1], OFS_RESULT_W1[5:1]: r_next.result_word_1 = w_merged;
          OFS_RESULT_W2[5:1]:                       r_next.res2 = w_merged;
          OFS_RESULT_W3[5:1]:                       r_next.result_word_3 = w_merged;
          OFS_CTL[5:1]: begin
            r_next.ctl = w_merged & CTL_RW_MASK;
          end
          default: begin
          end
        endcase
      end
    end

    // Blocked write parks in the slot; the bus is never stalled
    if (take_pend) begin
      r_next.pend_v = 1'b0;
    end
    if (WR_STB_I && !take_new) begin
      r_next.pend_v    = 1'b1;
      r_next.pend_addr = ADDR_I;
      r_next.pend_data = WR_DATA_I;
      r_next.pend_byte = BYTE_I;
    end

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic on the freshly written operands
    // mode field decode
    sgn_c    = r_next.ctl[CTL_MODE_LSB];
    accm_c   = r_next.ctl[CTL_MODE_LSB + 1];
    a_op     = r_next.ctl[CTL_OP1W_BIT] ? r_next.op1 :
               {{16{sgn_c & r_next.op1[15]}}, r_next.op1[15:0]};
    b_op     = r_next.ctl[CTL_OP2W_BIT] ? r_next.op2 :
               {{16{sgn_c & r_next.op2[15]}}, r_next.op2[15:0]};
    narrow_c = !r_next.ctl[CTL_OP1W_BIT] && !r_next.ctl[CTL_OP2W_BIT];
    a_x      = {sgn_c & a_op[31], a_op};
    b_x      = {sgn_c & b_op[31], b_op};
    prod     = $signed(a_x) * $signed(b_x);
    p64      = prod[63:0];
    if (r_next.ctl[CTL_FRAC_BIT]) begin
      p64 = {p64[62:0], 1'b0};
    end
    acc64 = accm_c ? {r_next.result_word_3, r_next.res2, r_next.result_word_1, r_next.result_word_0} :
                     64'h0000000000000000;

    if (narrow_c) begin
      sum33   = {1'b0, acc64[31:0]} + {1'b0, p64[31:0]};
      r32     = sum33[31:0];
      carry_c = accm_c & sum33[32];
      ovf_c   = accm_c & sgn_c & (acc64[31] == p64[31]) & (r32[31] != acc64[31]);
      if (r_next.ctl[CTL_SAT_BIT]) begin
        if (ovf_c) begin
          r32 = {acc64[31], {31{~acc64[31]}}};
        end else if (!sgn_c && carry_c) begin
          r32 = {32{1'b1}};
        end
      end
      res_c = {{32{sgn_c & r32[31]}}, r32};
      msb_c = r32[31];
    end else begin
      sum65   = {1'b0, acc64} + {1'b0, p64};
      res_c   = sum65[63:0];
      carry_c = accm_c & sum65[64];
      ovf_c   = accm_c & sgn_c & (acc64[63] == p64[63]) & (res_c[63] != acc64[63]);
      if (r_next.ctl[CTL_SAT_BIT]) begin
        if (ovf_c) begin
          res_c = {acc64[63], {63{~acc64[63]}}};
        end else if (!sgn_c && carry_c) begin
          res_c = {64{1'b1}};
        end
      end
      msb_c = res_c[63];
    end

    case (r_next.ctl[CTL_MODE_LSB +: 2])
      MODE_UMUL: sum_extension_c = 16'h0000;
      MODE_UMAC: sum_extension_c = {15'h0000, carry_c};
      default:   sum_extension_c = {16{msb_c}};
    endcase

    if (start_c) begin
      r_next.stage_res    = res_c;
      r_next.stage_carry  = carry_c;
      r_next.stage_sum_extension = sum_extension_c;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data stands one cycle after the strobe only
    r_next.rd_data = 16'h0000;
    if (RD_STB_I) begin
      rd_val = reg_value(r_reg, ADDR_I);
      if (BYTE_I) begin
        r_next.rd_data = {8'h00, ADDR_I[0] ? rd_val[15:8] : rd_val[7:0]};
      end else begin
        r_next.rd_data = rd_val;
      end
    end
    r_next.busy = start_c | sq.hi_busy;
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset clears the control word
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      r_reg <= '{ctl: CTL_RESET, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign RD_DATA_O     = r_reg.rd_data;
  assign RESULT_BUSY_O = r_reg.busy;
endmodule

/* core/hmc_lane_merge.sv */
`timescale 1ns/100ps
// Purpose: Merge a word or byte write into a 16-bit register value.
// Assumes: Byte data arrives in bits 7:0 of the write data.
// Notes:   Low-lane byte writes to operands may sign or zero extend.
module hmc_lane_merge (
  input  wire logic [15:0] old_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        byte_i,
  input  wire logic        hi_lane_i,
  input  wire logic        ext_i,
  input  wire logic        sign_i,
  output logic      [15:0] new_o
);
  always_comb begin
    if (!byte_i) begin
      new_o = wdata_i;
    end else if (hi_lane_i) begin
      new_o = {wdata_i[7:0], old_i[7:0]};
    end else if (ext_i) begin
      new_o = {{8{sign_i & wdata_i[7]}}, wdata_i[7:0]};
    end else begin
      new_o = {old_i[15:8], wdata_i[7:0]};
    end
  end
endmodule

/* core/hmc_seq.sv */
`timescale 1ns/100ps
// Purpose: Paces result availability: low 32 bits first, then all 64.
// Assumes: A new start restarts the count.
// Notes:   16x16 products finish both halves at the low-half count.
module hmc_seq (
  input  wire logic clk_i,
  input  wire logic rst_i,
  hmc_seq_if.seq    sq
);
  import hmc_pkg::*;

  typedef struct packed {
    hmc_seq_st_t st;
    logic [2:0]  cnt;
    logic [2:0]  last;
    logic        lo_busy;
    logic        lo_done;
    logic        hi_done;
  } hmc_seq_state_t;

  hmc_seq_state_t r_reg;
  hmc_seq_state_t r_next;

  always_comb begin
    r_next         = r_reg;
    r_next.lo_done = 1'b0;
    r_next.hi_done = 1'b0;
    case (r_reg.st)
      SEQ_IDLE: begin
        r_next.lo_busy = 1'b0;
      end
      SEQ_RUN: begin
        r_next.cnt = r_reg.cnt + 3'h1;
        if (r_next.cnt == LO_DONE_CYC) begin
          r_next.lo_done = 1'b1;
          r_next.lo_busy = 1'b0;
        end
        if (r_next.cnt == r_reg.last) begin
          r_next.hi_done = 1'b1;
          r_next.st      = SEQ_IDLE;
        end
      end
      default: begin
        r_next.st = SEQ_IDLE;
      end
    endcase
    if (sq.start) begin
      r_next.st      = SEQ_RUN;
      r_next.cnt     = 3'h0;
      r_next.last    = sq.narrow ? LO_DONE_CYC : FULL_DONE_CYC;
      r_next.lo_busy = 1'b1;
      r_next.lo_done = 1'b0;
      r_next.hi_done = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= '{st: SEQ_IDLE, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign sq.lo_done = r_reg.lo_done;
  assign sq.hi_done = r_reg.hi_done;
  assign sq.lo_busy = r_reg.lo_busy;
  assign sq.hi_busy = (r_reg.st == SEQ_RUN);
endmodule

/* inc/hmc_pkg.sv */
// Purpose: Shared constants and types of the multiplier control block.
// Assumes: Byte addressed register port, 16-bit data, 200 MHz system clock.
// Notes:   Offsets are byte offsets inside the block.
package hmc_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [5:0] OFS_OP1_16      = 6'h00;
  localparam logic [5:0] OFS_OP2         = 6'h08;
  localparam logic [5:0] OFS_RESULT_LOW  = 6'h0a;
  localparam logic [5:0] OFS_RESULT_HIGH = 6'h0c;
  localparam logic [5:0] OFS_SUM_EXT     = 6'h0e;
  localparam logic [5:0] OFS_OP1_32      = 6'h10;
  localparam logic [5:0] OFS_OP2_LOW     = 6'h20;
  localparam logic [5:0] OFS_OP2_HIGH    = 6'h22;
  localparam logic [5:0] OFS_RESULT_W0   = 6'h24;
  localparam logic [5:0] OFS_RESULT_W1   = 6'h26;
  localparam logic [5:0] OFS_RESULT_W2   = 6'h28;
  localparam logic [5:0] OFS_RESULT_W3   = 6'h2a;
  localparam logic [5:0] OFS_CTL         = 6'h2c;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int unsigned CTL_DLY_SEL_BIT = 9;
  localparam int unsigned CTL_DLY_EN_BIT  = 8;
  localparam int unsigned CTL_OP2W_BIT    = 7;
  localparam int unsigned CTL_OP1W_BIT    = 6;
  localparam int unsigned CTL_MODE_LSB    = 4;
  localparam int unsigned CTL_SAT_BIT     = 3;
  localparam int unsigned CTL_FRAC_BIT    = 2;
  localparam int unsigned CTL_CARRY_BIT   = 0;
  localparam logic [15:0] CTL_RW_MASK     = 16'h03fd;
  localparam logic [15:0] CTL_RESET       = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Timing, in system clock cycles after the starting write
  localparam logic [2:0] LO_DONE_CYC   = 3'h2;
  localparam logic [2:0] FULL_DONE_CYC = 3'h4;

  typedef enum logic [1:0] {
    MODE_UMUL = 2'b00,
    MODE_SMUL = 2'b01,
    MODE_UMAC = 2'b10,
    MODE_SMAC = 2'b11
  } hmc_mode_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_RUN  = 2'b10
  } hmc_seq_st_t;

endpackage

/* inc/hmc_seq_if.sv */
`timescale 1ns/100ps
// Purpose: Handshake between register control and result sequencer.
// Assumes: Single system clock.
// Notes:   start is a one-cycle pulse, done flags are one-cycle pulses.
interface hmc_seq_if;
  logic start;
  logic narrow;
  logic lo_done;
  logic hi_done;
  logic lo_busy;
  logic hi_busy;

  modport ctrl (output start, narrow, input lo_done, hi_done, lo_busy, hi_busy);
  modport seq  (input start, narrow, output lo_done, hi_done, lo_busy, hi_busy);
endinterface

/* tb/hmc_cpu.sv */
// Purpose: CPU side model driving the register port.
// Assumes: The slave never stalls; read data stands one cycle.
// Notes:   Strobes stay up between calls, so accesses may run back to back.
`timescale 1ns/100ps
module hmc_cpu (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  output logic      [5:0]  addr_o,
  output logic      [15:0] wdata_o,
  output logic             byte_o,
  output logic             wr_o,
  output logic             rd_o
);
  logic [15:0] q;

  initial begin
    addr_o  = 6'h00;
    wdata_o = 16'h0000;
    byte_o  = 1'b0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one register access per call; q samples the read data just after the edge
  task automatic xfer(input logic w, input logic [5:0] a, input logic [15:0] d,
                      input logic b);
    wr_o    <= w;
    rd_o    <= !w;
    addr_o  <= a;
    wdata_o <= d;
    byte_o  <= b;
    @(posedge clk_i);
    #1 q = rdata_i;
  endtask

  task automatic idle();
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask
endmodule

/* tb/hmc_ctrl_props.sv */
// Purpose: Port assertions of the multiplier control block.
// Assumes: Delayed writes stay off until the last tests.
// Notes:   Result alias checks rely on back-to-back reads while idle.
`timescale 1ns/100ps
module hmc_ctrl_props
  import hmc_pkg::*;
(
  input wire logic                       CLK_SYS_I,
  input wire logic                       SYS_RST_I,
  input wire logic [hmc_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [hmc_pkg::DATA_W-1:0] WR_DATA_I,
  input wire logic                       BYTE_I,
  input wire logic                       WR_STB_I,
  input wire logic                       RD_STB_I,
  input wire logic [hmc_pkg::DATA_W-1:0] RD_DATA_O,
  input wire logic                       RESULT_BUSY_O
);
  logic dly_reg;
  logic hi_wr_reg;
  wire  ctl_wr = WR_STB_I && ((ADDR_I == OFS_CTL && !BYTE_I) || (ADDR_I == 6'h2d && BYTE_I));

  // Parked writes would break the timing checks, so they stop here
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      dly_reg   <= 1'b0;
      hi_wr_reg <= 1'b0;
    end else if (ctl_wr) begin
      hi_wr_reg <= 1'b1;
      dly_reg   <= dly_reg | (BYTE_I ? WR_DATA_I[0] : WR_DATA_I[8]);
    end
  end

  default clocking dcb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (SYS_RST_I);

  ////////////////////////////////////////////////////////////////////////////
  a_ctl_reserved: assert property (
    RD_STB_I && ADDR_I == OFS_CTL && !BYTE_I |=> RD_DATA_O[15:10] == 6'h00 && !RD_DATA_O[1])
    else $error("control reserved bits read nonzero");
  a_ctl_hi_byte: assert property (
    RD_STB_I && ADDR_I == 6'h2d && BYTE_I |=> RD_DATA_O[15:2] == 14'h0000)
    else $error("control high byte reserved bits nonzero");
  a_ctl_hi_reset: assert property (
    RD_STB_I && ADDR_I == 6'h2d && BYTE_I && !hi_wr_reg |=> RD_DATA_O == 16'h0000)
    else $error("control high byte not zero after reset");
  a_busy_start: assert property (
    !dly_reg && WR_STB_I && ADDR_I == OFS_OP2 && !BYTE_I |=> RESULT_BUSY_O)
    else $error("operand two write did not start");
  a_busy_bound: assert property (
    $rose(RESULT_BUSY_O) |-> ##[1:8] !RESULT_BUSY_O)
    else $error("result never became ready");
  a_res_lo_alias: assert property (
    RD_STB_I && ADDR_I == OFS_RESULT_LOW && !BYTE_I && !RESULT_BUSY_O && !dly_reg ##1
    RD_STB_I && ADDR_I == OFS_RESULT_W0 && !BYTE_I |=> RD_DATA_O == $past(RD_DATA_O))
    else $error("result low word alias differs");
  a_res_hi_alias: assert property (
    RD_STB_I && ADDR_I == OFS_RESULT_HIGH && !BYTE_I && !RESULT_BUSY_O && !dly_reg ##1
    RD_STB_I && ADDR_I == OFS_RESULT_W1 && !BYTE_I |=> RD_DATA_O == $past(RD_DATA_O))
    else $error("result high word alias differs");
  a_op1_alias: assert property (
    RD_STB_I && ADDR_I == OFS_OP1_16 && !BYTE_I ##1
    RD_STB_I && ADDR_I == OFS_OP1_32 && !BYTE_I |=> RD_DATA_O == $past(RD_DATA_O))
    else $error("operand one alias differs");
  a_mode_alias: assert property (
    !dly_reg && WR_STB_I && !BYTE_I && ADDR_I[5:3] == 3'h0 && !ADDR_I[0] ##1
    RD_STB_I && ADDR_I == OFS_CTL && !BYTE_I
    |=> RD_DATA_O[6:4] == {1'b0, $past(ADDR_I[2:1], 2)})
    else $error("mode field does not follow operand address");
endmodule

bind hmc_ctrl hmc_ctrl_props hmc_ctrl_props_inst (
  .CLK_SYS_I     (CLK_SYS_I),
  .SYS_RST_I     (SYS_RST_I),
  .ADDR_I        (ADDR_I),
  .WR_DATA_I     (WR_DATA_I),
  .BYTE_I        (BYTE_I),
  .WR_STB_I      (WR_STB_I),
  .RD_STB_I      (RD_STB_I),
  .RD_DATA_O     (RD_DATA_O),
  .RESULT_BUSY_O (RESULT_BUSY_O)
);

/* tb/hmc_ctrl_test.sv */
// Purpose: Self-checking bench of the multiplier control block.
// Assumes: Delayed-write tests come last; checker is bound to the top.
// Notes:   Expected products are worked out by hand from the operands.
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module hmc_ctrl_test;
  import hmc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [5:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        byte_sel;
  logic        wr;
  logic        rd;
  logic        busy;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [15:0] dly_ctl [3] = '{16'h0040, 16'h0140, 16'h0340};
  logic [15:0] dly_exp [3] = '{16'h0000, 16'h5555, 16'h0000};

  always #2.5 clk_sys = ~clk_sys;

  hmc_ctrl hmc_ctrl_inst (
    .CLK_SYS_I     (clk_sys),
    .SYS_RST_I     (sys_rst),
    .ADDR_I        (addr),
    .WR_DATA_I     (wdata),
    .BYTE_I        (byte_sel),
    .WR_STB_I      (wr),
    .RD_STB_I      (rd),
    .RD_DATA_O     (rdata),
    .RESULT_BUSY_O (busy)
  );
  hmc_cpu hmc_cpu_inst (
    .clk_i   (clk_sys),
    .rdata_i (rdata),
    .addr_o  (addr),
    .wdata_o (wdata),
    .byte_o  (byte_sel),
    .wr_o    (wr),
    .rd_o    (rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d, input logic b = 1'b0);
    hmc_cpu_inst.xfer(1'b1, a, d, b);
    hmc_cpu_inst.idle();
  endtask

  task automatic rd_reg(input logic [5:0] a, input logic [15:0] e, input logic b = 1'b0);
    hmc_cpu_inst.xfer(1'b0, a, 16'h0000, b);
    hmc_cpu_inst.idle();
    `CHK($sformatf("reg %h", a), e, hmc_cpu_inst.q)
  endtask

  task automatic pair(input logic [5:0] a, input logic [5:0] b, input logic [15:0] e);
    hmc_cpu_inst.xfer(1'b0, a, 16'h0000, 1'b0);
    hmc_cpu_inst.xfer(1'b0, b, 16'h0000, 1'b0);
    hmc_cpu_inst.idle();
    `CHK($sformatf("alias %h", b), e, hmc_cpu_inst.q)
  endtask

  task automatic wait_idle();
    int n = 0;
    // Look after the edge so busy has settled
    repeat (2) @(posedge clk_sys);
    #1;
    while (busy !== 1'b0 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `CHK("busy", 1'b0, busy)
    @(posedge clk_sys);
    #1;
  endtask

  task automatic run(input logic [15:0] c, input logic [5:0] a, input logic [15:0] p,
                     input logic [15:0] s);
    wr_reg(OFS_CTL, c);
    wr_reg(a, p);
    wr_reg(OFS_OP2, s);
    wait_idle();
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    rd_reg(6'h2d, 16'h0000, 1'b1);
    rd_reg(OFS_CTL, CTL_RESET);
    wr_reg(OFS_CTL, 16'hfcff);
    rd_reg(OFS_CTL, 16'h00fd);
    wr_reg(6'h2d, 16'h0002, 1'b1);
    rd_reg(OFS_CTL, 16'h02fd);
    rd_reg(6'h2d, 16'h0002, 1'b1);
    wr_reg(OFS_CTL, 16'h0000, 1'b1);
    rd_reg(OFS_CTL, 16'h0200);
    wr_reg(OFS_CTL, 16'h0000);
    for (int m = 0; m < 4; m++) begin
      hmc_cpu_inst.xfer(1'b1, 6'(2 * m), 16'h1230 + 16'(m), 1'b0);
      hmc_cpu_inst.xfer(1'b0, OFS_CTL, 16'h0000, 1'b0);
      hmc_cpu_inst.idle();
      `CHK("mode field", 16'(m) << 4, hmc_cpu_inst.q)
      pair(6'(2 * m), OFS_OP1_32 + 6'(4 * m), 16'h1230 + 16'(m));
    end
    wr_reg(6'h12, 16'h0001);
    rd_reg(OFS_CTL, 16'h0040);
    wr_reg(OFS_OP2_HIGH, 16'h0000);
    wait_idle();
    rd_reg(OFS_CTL, 16'h00c0);
    run(16'h0000, OFS_OP1_16, 16'h1234, 16'h0010);
    pair(OFS_RESULT_LOW, OFS_RESULT_W0, 16'h2340);
    pair(OFS_RESULT_HIGH, OFS_RESULT_W1, 16'h0001);
    rd_reg(OFS_CTL, 16'h0000);
    run(16'h0004, OFS_OP1_16, 16'h1234, 16'h0010);
    rd_reg(OFS_RESULT_LOW, 16'h4680);
    wr_reg(OFS_RESULT_LOW, 16'hffff);
    wr_reg(OFS_RESULT_HIGH, 16'hffff);
    run(16'h0000, 6'h04, 16'h0001, 16'h0001);
    rd_reg(OFS_RESULT_HIGH, 16'h0000);
    rd_reg(OFS_CTL, 16'h0021);
    rd_reg(OFS_SUM_EXT, 16'h0001);
    wr_reg(OFS_CTL, 16'h002d);
    rd_reg(OFS_CTL, 16'h002d);
    rd_reg(OFS_SUM_EXT, 16'h0001);
    wr_reg(OFS_CTL, 16'h0020);
    rd_reg(OFS_SUM_EXT, 16'h0000);
    wr_reg(OFS_RESULT_LOW, 16'hffff);
    wr_reg(OFS_RESULT_HIGH, 16'hffff);
    run(16'h0008, 6'h04, 16'h0001, 16'h0001);
    rd_reg(OFS_RESULT_LOW, 16'hffff);
    // Signed 16x16: -1 times 2 gives -2, extension all ones
    run(16'h0000, 6'h02, 16'hffff, 16'h0002);
    rd_reg(OFS_RESULT_LOW, 16'hfffe);
    rd_reg(OFS_RESULT_HIGH, 16'hffff);
    rd_reg(OFS_SUM_EXT, 16'hffff);
    wr_reg(OFS_OP1_32, 16'h0000);
    wr_reg(6'h12, 16'h0001);
    // Result word 2 is written while the product is still running
    for (int i = 0; i < 3; i++) begin
      wr_reg(OFS_CTL, dly_ctl[i]);
      hmc_cpu_inst.xfer(1'b1, OFS_OP2, 16'h0003, 1'b0);
      hmc_cpu_inst.xfer(1'b1, OFS_RESULT_W2, 16'h5555, 1'b0);
      hmc_cpu_inst.idle();
      wait_idle();
      rd_reg(OFS_RESULT_W2, dly_exp[i]);
    end
    final_report();
  end
endmodule
